/* hrs_consts.svh */
// constants for the hardware return stack: offsets, fields, resets, vectors
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define HRS_PC_W        21
`define HRS_PTR_W       5
`define HRS_DEPTH       31
`define HRS_PTR_MAX     5'h1F
`define HRS_PTR_LAST    5'h1E

// ----------------------------------------------------------------------------
// register offsets (byte index on the plain register port)
// ----------------------------------------------------------------------------
`define HRS_ADDR_W      8
`define HRS_OFF_STATUS  8'h00
`define HRS_OFF_TOP_LO  8'h01
`define HRS_OFF_TOP_HI  8'h02
`define HRS_OFF_TOP_UP  8'h03
`define HRS_OFF_CFG     8'h04

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define HRS_BIT_FULL    7
`define HRS_BIT_UNF     6
`define HRS_BIT_OVRST   0
`define HRS_RST_CFG     1'h1

// ----------------------------------------------------------------------------
// program counter values
// ----------------------------------------------------------------------------
`define HRS_PC_STEP     21'h000002
`define HRS_VEC_HIGH    21'h000008
`define HRS_VEC_LOW     21'h000018

`endif

/* hrs_pkg.sv */
// types shared by the hardware return stack
`default_nettype none
`include "hrs_consts.svh"

package hrs_pkg;

  // request from the core sequencer
  typedef struct packed {
    logic                 push;
    logic                 pop;
    logic [`HRS_PC_W-1:0] pc;
  } hrs_core_req_t;

  // answer back to the core sequencer
  typedef struct packed {
    logic                 pc_valid;
    logic [`HRS_PC_W-1:0] pc;
    logic                 vec_load;
    logic [`HRS_PC_W-1:0] vec_addr;
    logic                 dev_reset;
  } hrs_core_rsp_t;

endpackage : hrs_pkg

`default_nettype wire

/* hrs_stack_mem.sv */
// flip-flop storage for the return stack entries, index 1 to depth
`default_nettype none
`include "hrs_consts.svh"

module hrs_stack_mem
  import hrs_pkg::*;
#(
  parameter int DEPTH = `HRS_DEPTH,
  parameter int PC_W  = `HRS_PC_W,
  parameter int PTR_W = `HRS_PTR_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // write port
  input  wire logic             wr_en,
  input  wire logic [PTR_W-1:0] wr_idx,
  input  wire logic [PC_W-1:0]  wr_data,
  // read port
  input  wire logic [PTR_W-1:0] rd_idx,
  output logic      [PC_W-1:0]  rd_data
);

  logic [PC_W-1:0] entry_r [1:DEPTH];

  // ---------------------------------------------------------------------------
  // one register per entry
  // ---------------------------------------------------------------------------
  for (genvar g = 1; g <= DEPTH; g++) begin : g_entry
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        entry_r[g] <= '0;
      end else if (wr_en && (wr_idx == PTR_W'(g))) begin
        entry_r[g] <= wr_data;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // read: index zero reads as zero
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    for (int i = 1; i <= DEPTH; i++) begin
      if (rd_idx == PTR_W'(i)) begin
        rd_data = entry_r[i];
      end
    end
  end

endmodule : hrs_stack_mem

`default_nettype wire

/* hrs_return_stack.sv */
// hardware return-address stack with pointer, flags and top-entry access
//
// What this block does
// - five-bit stack level pointer, legal values zero to thirty-one.
// - push increments pointer then writes; pop reads then decrements.
// - any device reset returns the pointer to zero.
// - software reads and writes the pointer through the status register.
// - thirty-one pushes without a pop set the overflow flag.
// - overflow flag stays until software clear or power-on reset.
// - with overflow reset on, 31st push stores pc plus two, flags, resets.
// - with overflow reset off, pointer sticks at 31, entry kept.
// - pop at pointer zero returns zero, sets underflow, pointer stays zero.
// - underflow flag stays until software clear or power-on reset.
// - underflow returning zero is no reset; registers untouched.
// - push instruction increments pointer and stores current pc.
// - pop instruction decrements pointer, earlier entry becomes top.
// - top entry read and written as upper, high and low bytes.
// - interrupt wake-up with a global enable pushes pc, advances pointer.
// - interrupt wake-up loads pc with vector 0008h or 0018h.
// - flag writes only clear; both flags zero at power-on.
//
// Local design decisions: the strobed register port and the placing of the registers.
`default_nettype none
`include "hrs_consts.svh"

module hrs_return_stack
  import hrs_pkg::*;
#(
  parameter int DEPTH = `HRS_DEPTH
) (
  // clock and power-on reset
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  // other device resets, synchronous
  input  wire logic                   dev_rst,
  // register port
  input  wire logic [`HRS_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // core sequencer
  input  var  hrs_core_req_t          core_req,
  output hrs_core_rsp_t               core_rsp,
  // interrupt wake-up
  input  wire logic                   wake_int,
  input  wire logic                   wake_low_prio,
  input  wire logic                   global_int_enable_low,
  input  wire logic                   global_int_enable_high
);

  localparam int PC_W  = `HRS_PC_W;
  localparam int PTR_W = `HRS_PTR_W;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [PTR_W-1:0] stack_level_pointer_r;
  logic [PTR_W-1:0] stack_level_pointer_nxt;
  logic             stack_overflow_flag_r;
  logic             stack_overflow_flag_nxt;
  logic             stack_underflow_flag_r;
  logic             stack_underflow_flag_nxt;
  logic             overflow_reset_cfg_r;
  logic [7:0]       rdata_r;
  logic             pc_valid_r;
  logic [PC_W-1:0]  pc_r;
  logic             vec_load_r;
  logic [PC_W-1:0]  vec_addr_r;
  logic             dev_reset_r;

  // ---------------------------------------------------------------------------
  // decoded events
  // ---------------------------------------------------------------------------
  logic             do_wake;
  logic             do_push;
  logic             do_pop;
  logic             ptr_zero;
  logic             ptr_last;
  logic             ptr_max;
  logic             push_overflows;
  logic             push_stores;
  logic             ovf_reset;
  logic             wr_status;
  logic             wr_top_lo;
  logic             wr_top_hi;
  logic             wr_top_up;
  logic             wr_cfg;
  logic             wr_top;
  logic [PC_W-1:0]  top_entry;
  logic [PC_W-1:0]  top_merged;
  logic             mem_wr_en;
  logic [PTR_W-1:0] mem_wr_idx;
  logic [PC_W-1:0]  mem_wr_data;
  logic [7:0]       status_view;

  // wake-up pushes only with either global enable set
  assign do_wake  = wake_int && (global_int_enable_low || global_int_enable_high);
  assign do_push  = core_req.push || do_wake;
  assign do_pop   = core_req.pop && !do_push;

  assign ptr_zero = (stack_level_pointer_r == '0);
  assign ptr_last = (stack_level_pointer_r == `HRS_PTR_LAST);
  assign ptr_max  = (stack_level_pointer_r == `HRS_PTR_MAX);

  // the 31st push, or any push once the stack is full
  assign push_overflows = do_push && (ptr_last || ptr_max) && !dev_rst;
  assign push_stores    = do_push && !ptr_max && !dev_rst;
  assign ovf_reset      = push_overflows && overflow_reset_cfg_r;

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  always_comb begin
    wr_status = 1'b0;
    wr_top_lo = 1'b0;
    wr_top_hi = 1'b0;
    wr_top_up = 1'b0;
    wr_cfg    = 1'b0;
    if (reg_wr && (reg_addr == `HRS_OFF_STATUS)) begin
      wr_status = 1'b1;
    end else if (reg_wr && (reg_addr == `HRS_OFF_TOP_LO)) begin
      wr_top_lo = 1'b1;
    end else if (reg_wr && (reg_addr == `HRS_OFF_TOP_HI)) begin
      wr_top_hi = 1'b1;
    end else if (reg_wr && (reg_addr == `HRS_OFF_TOP_UP)) begin
      wr_top_up = 1'b1;
    end else if (reg_wr && (reg_addr == `HRS_OFF_CFG)) begin
      wr_cfg = 1'b1;
    end
  end

  assign wr_top = wr_top_lo || wr_top_hi || wr_top_up;

  // ---------------------------------------------------------------------------
  // entry storage
  // ---------------------------------------------------------------------------
  hrs_stack_mem #(
    .DEPTH (DEPTH),
    .PC_W  (PC_W),
    .PTR_W (PTR_W)
  ) u_mem (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .wr_en   (mem_wr_en),
    .wr_idx  (mem_wr_idx),
    .wr_data (mem_wr_data),
    .rd_idx  (stack_level_pointer_r),
    .rd_data (top_entry)
  );

  // byte merge of a software write into the top entry
  always_comb begin
    top_merged = top_entry;
    if (wr_top_lo) begin
      top_merged[7:0] = reg_wdata;
    end
    if (wr_top_hi) begin
      top_merged[15:8] = reg_wdata;
    end
    if (wr_top_up) begin
      top_merged[PC_W-1:16] = reg_wdata[PC_W-17:0];
    end
  end

  // hardware push beats a software top write in the same cycle
  always_comb begin
    mem_wr_en   = 1'b0;
    mem_wr_idx  = stack_level_pointer_r;
    mem_wr_data = top_merged;
    if (push_stores) begin
      mem_wr_en  = 1'b1;
      mem_wr_idx = stack_level_pointer_r + PTR_W'(1);
      if (ovf_reset) begin
        mem_wr_data = core_req.pc + `HRS_PC_STEP;
      end else begin
        mem_wr_data = core_req.pc;
      end
    end else if (wr_top && !ptr_zero && !dev_rst && !do_push && !do_pop) begin
      mem_wr_en = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // stack level pointer
  // ---------------------------------------------------------------------------
  always_comb begin
    stack_level_pointer_nxt = stack_level_pointer_r;
    if (dev_rst) begin
      stack_level_pointer_nxt = '0;
    end else if (do_push) begin
      if (ovf_reset) begin
        stack_level_pointer_nxt = '0;
      end else if (ptr_last || ptr_max) begin
        stack_level_pointer_nxt = `HRS_PTR_MAX;
      end else begin
        stack_level_pointer_nxt = stack_level_pointer_r + PTR_W'(1);
      end
    end else if (do_pop) begin
      if (!ptr_zero) begin
        stack_level_pointer_nxt = stack_level_pointer_r - PTR_W'(1);
      end
    end else if (wr_status) begin
      stack_level_pointer_nxt = reg_wdata[PTR_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stack_level_pointer_r <= '0;
    end else begin
      stack_level_pointer_r <= stack_level_pointer_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // sticky flags: writes of zero clear, hardware set wins
  // ---------------------------------------------------------------------------
  always_comb begin
    stack_overflow_flag_nxt = stack_overflow_flag_r;
    if (wr_status && !reg_wdata[`HRS_BIT_FULL]) begin
      stack_overflow_flag_nxt = 1'b0;
    end
    if (push_overflows) begin
      stack_overflow_flag_nxt = 1'b1;
    end
  end

  always_comb begin
    stack_underflow_flag_nxt = stack_underflow_flag_r;
    if (wr_status && !reg_wdata[`HRS_BIT_UNF]) begin
      stack_underflow_flag_nxt = 1'b0;
    end
    if (do_pop && ptr_zero && !dev_rst) begin
      stack_underflow_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stack_overflow_flag_r  <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
    end else begin
      stack_overflow_flag_r  <= stack_overflow_flag_nxt;
      stack_underflow_flag_r <= stack_underflow_flag_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overflow_reset_cfg_r <= `HRS_RST_CFG;
    end else if (wr_cfg) begin
      overflow_reset_cfg_r <= reg_wdata[`HRS_BIT_OVRST];
    end
  end

  // ---------------------------------------------------------------------------
  // register read, data valid in the cycle after the strobe only
  // ---------------------------------------------------------------------------
  always_comb begin
    status_view                      = '0;
    status_view[`HRS_BIT_FULL]       = stack_overflow_flag_r;
    status_view[`HRS_BIT_UNF]        = stack_underflow_flag_r;
    status_view[PTR_W-1:0]           = stack_level_pointer_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else if (!reg_rd) begin
      rdata_r <= '0;
    end else if (reg_addr == `HRS_OFF_STATUS) begin
      rdata_r <= status_view;
    end else if (reg_addr == `HRS_OFF_TOP_LO) begin
      rdata_r <= top_entry[7:0];
    end else if (reg_addr == `HRS_OFF_TOP_HI) begin
      rdata_r <= top_entry[15:8];
    end else if (reg_addr == `HRS_OFF_TOP_UP) begin
      rdata_r <= {3'h0, top_entry[PC_W-1:16]};
    end else if (reg_addr == `HRS_OFF_CFG) begin
      rdata_r <= {7'h00, overflow_reset_cfg_r};
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------------------
  // answers to the core
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc_valid_r <= 1'b0;
      pc_r       <= '0;
    end else begin
      pc_valid_r <= do_pop && !dev_rst;
      if (do_pop && !dev_rst) begin
        pc_r <= ptr_zero ? '0 : top_entry;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vec_load_r <= 1'b0;
      vec_addr_r <= '0;
    end else begin
      vec_load_r <= do_wake && !dev_rst;
      if (do_wake && !dev_rst) begin
        vec_addr_r <= wake_low_prio ? `HRS_VEC_LOW : `HRS_VEC_HIGH;
      end
    end
  end

  // only the overflow path requests a reset; underflow never does
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dev_reset_r <= 1'b0;
    end else begin
      dev_reset_r <= ovf_reset;
    end
  end

  always_comb begin
    core_rsp.pc_valid  = pc_valid_r;
    core_rsp.pc        = pc_r;
    core_rsp.vec_load  = vec_load_r;
    core_rsp.vec_addr  = vec_addr_r;
    core_rsp.dev_reset = dev_reset_r;
  end

endmodule : hrs_return_stack

`default_nettype wire

/* hrs_return_stack_chk.sv */
// port-level checks for the hardware return stack
`default_nettype none
`include "hrs_consts.svh"

module hrs_return_stack_chk
  import hrs_pkg::*;
#(
  parameter int DEPTH = `HRS_DEPTH
) (
  // clock and resets
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   dev_rst,
  // register port
  input  wire logic [`HRS_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_rdata,
  // core sequencer
  input  var  hrs_core_req_t          core_req,
  input  var  hrs_core_rsp_t          core_rsp,
  // interrupt wake-up
  input  wire logic                   wake_int,
  input  wire logic                   wake_low_prio,
  input  wire logic                   global_int_enable_low,
  input  wire logic                   global_int_enable_high
);
  timeunit 1ns;
  timeprecision 1ps;

  logic wake_on;
  logic quiet;

  assign wake_on = wake_int && (global_int_enable_low || global_int_enable_high);
  assign quiet   = !core_req.push && !core_req.pop && !dev_rst && !wake_int;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_pop_answer: assert property (
    core_req.pop && !core_req.push && !wake_on && !dev_rst |=> core_rsp.pc_valid)
    else $error("pop gave no popped value");
  chk_valid_cause: assert property (
    core_rsp.pc_valid |-> $past(core_req.pop) && !$past(core_req.push))
    else $error("popped value without a lone pop");
  chk_wake_vector: assert property (wake_on && !dev_rst |=> core_rsp.vec_load &&
    core_rsp.vec_addr == ($past(wake_low_prio) ? `HRS_VEC_LOW : `HRS_VEC_HIGH))
    else $error("wrong or missing interrupt vector");
  chk_wake_masked: assert property (
    wake_int && !global_int_enable_low && !global_int_enable_high |=> !core_rsp.vec_load)
    else $error("vector load with both enables clear");
  chk_status_bit5: assert property (
    reg_rd && reg_addr == `HRS_OFF_STATUS |=> !reg_rdata[5])
    else $error("status bit 5 not zero");
  chk_upper_bits: assert property (
    reg_rd && reg_addr == `HRS_OFF_TOP_UP |=> reg_rdata[7:5] == 3'h0)
    else $error("upper top byte spare bits not zero");
  chk_reset_cause: assert property (
    core_rsp.dev_reset |-> ($past(core_req.push) || $past(wake_on)) ##1 !core_rsp.dev_reset)
    else $error("overflow reset request without push or too long");
  chk_ptr_write: assert property (
    reg_wr && reg_addr == `HRS_OFF_STATUS && quiet ##1 quiet && !reg_wr
    ##1 reg_rd && reg_addr == `HRS_OFF_STATUS && quiet
    |=> (reg_rdata & 8'h1F) == ($past(reg_wdata, 3) & 8'h1F))
    else $error("pointer write not read back");

endmodule : hrs_return_stack_chk

bind hrs_return_stack hrs_return_stack_chk #(.DEPTH(DEPTH)) i_chk (
  .clk_sys, .arst_n, .dev_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .core_req, .core_rsp, .wake_int, .wake_low_prio, .global_int_enable_low,
  .global_int_enable_high
);

`default_nettype wire

/* hrs_core_model.sv */
// core sequencer model driving push, pop and wake-up requests
`default_nettype none

module hrs_core_model
  import hrs_pkg::*;
(
  // clock
  input  wire logic    clk_sys,
  // sequencer side
  output var hrs_core_req_t core_req,
  input  var hrs_core_rsp_t core_rsp,
  // wake-up
  output var logic     wake_int,
  output var logic     wake_low_prio,
  output var logic     global_int_enable_low,
  output var logic     global_int_enable_high
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [20:0] next_pc = '0;
  int          reset_reqs = 0;

  initial begin
    core_req = '0;
    wake_int = 1'b0;
    wake_low_prio = 1'b0;
    global_int_enable_low = 1'b0;
    global_int_enable_high = 1'b0;
  end

  // popped value becomes the next program counter
  always @(posedge clk_sys) begin
    if (core_rsp.pc_valid === 1'b1) next_pc <= core_rsp.pc;
    if (core_rsp.dev_reset === 1'b1) reset_reqs <= reset_reqs + 1;
  end

  // one request per event, held one cycle
  task automatic req(input logic psh, input logic pp, input logic [20:0] pc);
    @(posedge clk_sys);
    core_req <= '{push: psh, pop: pp, pc: pc};
    @(posedge clk_sys);
    core_req <= '0;
    #1;
  endtask : req

  task automatic wake(input logic lp, input logic gl, input logic gh, input logic [20:0] pc);
    @(posedge clk_sys);
    wake_int <= 1'b1;
    wake_low_prio <= lp;
    global_int_enable_low <= gl;
    global_int_enable_high <= gh;
    core_req.pc <= pc;
    @(posedge clk_sys);
    wake_int <= 1'b0;
    #1;
  endtask : wake

endmodule : hrs_core_model

`default_nettype wire

/* hrs_return_stack_tb.sv */
// self-checking testbench for the hardware return stack
`default_nettype none
`include "hrs_consts.svh"

module hrs_return_stack_tb
  import hrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clk_sys, arst_n, dev_rst, reg_wr, reg_rd;
  logic [7:0]    reg_addr, reg_wdata, reg_rdata;
  hrs_core_req_t core_req;
  hrs_core_rsp_t core_rsp;
  logic          wake_int, wake_low_prio, global_int_enable_low, global_int_enable_high;
  int            fail_count, total_checks;

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  hrs_return_stack #(.DEPTH(`HRS_DEPTH)) i_dut (
    .clk_sys, .arst_n, .dev_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .core_req, .core_rsp, .wake_int, .wake_low_prio, .global_int_enable_low,
    .global_int_enable_high);
  hrs_core_model i_core (.clk_sys, .core_req, .core_rsp, .wake_int, .wake_low_prio,
    .global_int_enable_low, .global_int_enable_high);

  // ---------------------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(what, {24'h0, reg_rdata}, {24'h0, exp});
  endtask : rc

  task automatic top_chk(input logic [20:0] e);
    rc("top low", `HRS_OFF_TOP_LO, e[7:0]);
    rc("top high", `HRS_OFF_TOP_HI, e[15:8]);
    rc("top upper", `HRS_OFF_TOP_UP, {3'h0, e[20:16]});
  endtask : top_chk

  task automatic popc(input logic [20:0] e);
    i_core.req(1'b0, 1'b1, 21'h0);
    check("pop valid", core_rsp.pc_valid, 1);
    check("popped pc", core_rsp.pc, e);
    @(posedge clk_sys);
    #1;
    check("next pc", i_core.next_pc, e);
  endtask : popc

  task automatic pulse_dev_rst();
    @(posedge clk_sys);
    dev_rst <= 1'b1;
    @(posedge clk_sys);
    dev_rst <= 1'b0;
  endtask : pulse_dev_rst

  task automatic fill();
    for (int i = 1; i <= 30; i++) i_core.req(1'b1, 1'b0, 21'(i));
  endtask : fill

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    dev_rst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rc("status", `HRS_OFF_STATUS, 8'h00);
    rc("config", `HRS_OFF_CFG, 8'h01);
    rc("unmapped", 8'h05, 8'h00);
    done("reset");
    i_core.req(1'b1, 1'b0, 21'h012345);
    i_core.req(1'b1, 1'b1, 21'h0ABCDE);
    check("push wins", core_rsp.pc_valid, 0);
    rc("status", `HRS_OFF_STATUS, 8'h02);
    top_chk(21'h0ABCDE);
    popc(21'h0ABCDE);
    rc("status", `HRS_OFF_STATUS, 8'h01);
    top_chk(21'h012345);
    wr(`HRS_OFF_TOP_UP, 8'hFF);
    wr(`HRS_OFF_TOP_HI, 8'h56);
    wr(`HRS_OFF_TOP_LO, 8'h78);
    top_chk(21'h1F5678);
    popc(21'h1F5678);
    top_chk(21'h000000);
    done("push pop");
    popc(21'h000000);
    rc("status", `HRS_OFF_STATUS, 8'h40);
    rc("config", `HRS_OFF_CFG, 8'h01);
    check("reset requests", i_core.reset_reqs, 0);
    wr(`HRS_OFF_STATUS, 8'hC0);
    rc("status", `HRS_OFF_STATUS, 8'h40);
    wr(`HRS_OFF_STATUS, 8'h05);
    rc("status", `HRS_OFF_STATUS, 8'h05);
    pulse_dev_rst();
    rc("status", `HRS_OFF_STATUS, 8'h00);
    done("underflow");
    wr(`HRS_OFF_CFG, 8'h00);
    fill();
    rc("status", `HRS_OFF_STATUS, 8'h1E);
    i_core.req(1'b1, 1'b0, 21'h00001F);
    rc("status", `HRS_OFF_STATUS, 8'h9F);
    i_core.req(1'b1, 1'b0, 21'h1FFFFF);
    rc("status", `HRS_OFF_STATUS, 8'h9F);
    top_chk(21'h00001F);
    pulse_dev_rst();
    rc("status", `HRS_OFF_STATUS, 8'h80);
    wr(`HRS_OFF_STATUS, 8'h00);
    rc("status", `HRS_OFF_STATUS, 8'h00);
    done("saturate");
    wr(`HRS_OFF_CFG, 8'h01);
    fill();
    i_core.req(1'b1, 1'b0, 21'h000100);
    rc("status", `HRS_OFF_STATUS, 8'h80);
    check("reset requests", i_core.reset_reqs, 1);
    wr(`HRS_OFF_STATUS, 8'h9F);
    top_chk(21'h000100 + `HRS_PC_STEP);
    i_core.req(1'b1, 1'b0, 21'h000500);
    rc("status", `HRS_OFF_STATUS, 8'h80);
    check("reset requests", i_core.reset_reqs, 2);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rc("status", `HRS_OFF_STATUS, 8'h00);
    done("overflow reset");
    i_core.wake(1'b0, 1'b0, 1'b0, 21'h000200);
    check("vector load", core_rsp.vec_load, 0);
    rc("status", `HRS_OFF_STATUS, 8'h00);
    i_core.wake(1'b1, 1'b1, 1'b0, 21'h000300);
    check("vector load", core_rsp.vec_load, 1);
    check("vector", core_rsp.vec_addr, `HRS_VEC_LOW);
    top_chk(21'h000300);
    i_core.wake(1'b0, 1'b0, 1'b1, 21'h000400);
    check("vector", core_rsp.vec_addr, `HRS_VEC_HIGH);
    rc("status", `HRS_OFF_STATUS, 8'h02);
    done("wake");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("run timed out");
    print_verdict();
  end

endmodule : hrs_return_stack_tb

`default_nettype wire
